// ==== design/pfd_frame_decoder.sv ====
// Peripheral frame decoder: window lookup, write protection and frame bridging
// Overview of operation
// - Protected window writes dropped unless writes unlocked
// - Lock instruction clears the write unlock state
// - Key window at 0x0AE0 frame 0, protected
// - Flash window protected and gated by code protection
// - Frame 0 takes 16-bit and 32-bit accesses
// - Converter results read-only, DMA 0, CPU 1 wait
// - Remap bit set moves pulse-width windows to 0x5800
// - Remap bit clear keeps pulse-width windows at 0x6800
// - Map configuration writes need the write unlock
// - Frame 0 served straight from memory bus
// - Frame 1 reached over 32-bit peripheral bus
// - Frame 2 reached over 16-bit peripheral bus
// - Frame 3 reached over DMA-capable 32-bit bus
// - Vector table protected, expander control not protected
// - Timer window at 0x0C00 frame 0, unprotected
// - DMA register window at 0x1000 frame 0, protected
// - External memory window at 0x0B20 protected
// - Emulation window at 0x0880 frame 0, protected
`timescale 1ns/10ps
module pfd_frame_decoder
  import pfd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic write_unlock_instr,
  input wire logic write_lock_instr,
  input wire logic cprot_open,
  input wire pfd_req_t cpu_req,
  input wire pfd_req_t dma_req,
  input wire logic [3:0] f_ack,
  input wire logic [3:0][31:0] f_rdata,
  output pfd_rsp_t cpu_rsp,
  output pfd_rsp_t dma_rsp,
  output pfd_fport_t [3:0] f_port,
  output logic unlock_state,
  output logic pwm_remap_bit
);
  // Frame of a window index
  function automatic logic [1:0] win_frame(input logic [4:0] i);
    if (i >= PFD_F3_FIRST) begin
      win_frame = PFD_FRAME3;
    end else if (i >= PFD_F2_FIRST) begin
      win_frame = PFD_FRAME2;
    end else if (i >= PFD_F1_FIRST) begin
      win_frame = PFD_FRAME1;
    end else begin
      win_frame = PFD_FRAME0;
    end
  endfunction : win_frame

  // Sequencer state
  pfd_state_t state_reg;
  pfd_state_t state_next;
  // Latched request and its source, 1 for DMA
  pfd_req_t cur_reg;
  logic src_dma_reg;
  logic [1:0] frm_reg;
  // Frame 2 split tracking and assembled read data
  logic split_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic [1:0] wait_reg;
  // Write unlock state and local register
  logic unlock_reg;
  logic remap_reg;
  logic [15:0] map_rdata;
  logic map_wr;
  // Selected incoming request and its decode
  pfd_req_t in_req;
  logic in_dma;
  logic in_hit;
  logic [4:0] in_idx;
  pfd_kind_t in_kind;
  logic take;
  // Registered outputs
  pfd_rsp_t cpu_rsp_reg;
  pfd_rsp_t dma_rsp_reg;
  pfd_fport_t [3:0] f_port_reg;

  assign cpu_rsp = cpu_rsp_reg;
  assign dma_rsp = dma_rsp_reg;
  assign f_port = f_port_reg;
  assign unlock_state = unlock_reg;
  assign pwm_remap_bit = remap_reg;

  // CPU has priority; DMA waits while the CPU holds a request
  always_comb begin
    in_dma = !cpu_req.valid;
    in_req = cpu_req.valid ? cpu_req : dma_req;
  end
  assign take = (state_reg == PFD_S_IDLE) && in_req.valid;

  // Window lookup, remap bit picks frame 1 or frame 3 for pulse-width
  pfd_window_decode u_decode (
    .addr(in_req.addr),
    .remap(remap_reg),
    .hit(in_hit),
    .idx(in_idx)
  );

  // Classify the incoming request
  always_comb begin
    in_kind = PFD_K_FRAME;
    if (!in_hit || (in_dma && !PFD_MASK_DMA[in_idx])) begin
      // Unmapped, or a window outside the DMA's reach
      in_kind = PFD_K_ERR;
    end else if (PFD_MASK_CPROT[in_idx] && !cprot_open) begin
      // Flash control hidden while code protection is locked
      in_kind = in_req.write ? PFD_K_DROP : PFD_K_ZERO;
    end else if (in_req.write && PFD_MASK_RO[in_idx]) begin
      in_kind = PFD_K_DROP;
    end else if (in_req.write && PFD_MASK_PROT[in_idx] && !unlock_reg) begin
      // Covers emulation, flash, key, memory interface, vectors, DMA, map configuration
      in_kind = PFD_K_DROP;
    end else if (in_idx == PFD_WIN_MAPCFG) begin
      in_kind = PFD_K_LOCAL;
    end
  end

  // Map register is written from the idle cycle; the lock is rechecked inside
  assign map_wr = take && (in_kind == PFD_K_LOCAL) && in_req.write;

  pfd_map_reg u_map (
    .clk(clk),
    .reset_n(reset_n),
    .wr_stb(map_wr),
    .wdata(in_req.wdata[15:0]),
    .unlocked(unlock_reg),
    .remap_reg(remap_reg),
    .rdata(map_rdata)
  );

  // Write unlock state; a lock in the same cycle wins, the safer outcome
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_reg <= PFD_UNLOCK_RESET;
    end else if (write_lock_instr) begin
      unlock_reg <= 1'b0;
    end else if (write_unlock_instr) begin
      unlock_reg <= 1'b1;
    end
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PFD_S_IDLE: begin
        if (take) begin
          state_next = (in_kind == PFD_K_FRAME) ? PFD_S_ISSUE : PFD_S_DONE;
        end
      end
      PFD_S_ISSUE: begin
        if (f_ack[frm_reg]) begin
          if (split_reg) begin
            // Second half of a wide access on the 16-bit bus
            state_next = PFD_S_HALF;
          end else if (wait_reg != 2'h0) begin
            state_next = PFD_S_HOLD;
          end else begin
            state_next = PFD_S_DONE;
          end
        end
      end
      PFD_S_HALF: begin
        state_next = PFD_S_ISSUE;
      end
      PFD_S_HOLD: begin
        if (wait_reg == 2'h1) begin
          state_next = PFD_S_DONE;
        end
      end
      PFD_S_DONE: begin
        state_next = PFD_S_IDLE;
      end
      default: begin
        state_next = PFD_S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PFD_S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latch the request on take; the master holds it anyway
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_reg <= '0;
      src_dma_reg <= 1'b0;
      frm_reg <= PFD_FRAME0;
    end else if (take) begin
      cur_reg <= in_req;
      src_dma_reg <= in_dma;
      frm_reg <= win_frame(in_idx);
    end
  end

  // Split flag: wide access on frame 2 takes two 16-bit beats
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      split_reg <= 1'b0;
    end else if (take) begin
      split_reg <= in_req.wide && (win_frame(in_idx) == PFD_FRAME2);
    end else if (state_reg == PFD_S_ISSUE && f_ack[frm_reg]) begin
      split_reg <= 1'b0;
    end
  end

  // Wait count: converter results cost the CPU one extra cycle, DMA none
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 2'h0;
    end else if (take) begin
      if (in_hit && in_idx == PFD_WIN_ADCRES) begin
        wait_reg <= in_dma ? PFD_ADC_DMA_WAIT : PFD_ADC_CPU_WAIT;
      end else begin
        wait_reg <= 2'h0;
      end
    end else if (state_reg == PFD_S_HOLD) begin
      wait_reg <= wait_reg - 2'h1;
    end
  end

  // Frame ports: one-cycle select pulse, fields held until the next issue
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f_port_reg <= '0;
    end else begin
      for (int f = 0; f < 4; f++) begin
        f_port_reg[f].sel <= 1'b0;
      end
      if (take && in_kind == PFD_K_FRAME) begin
        // Dropped writes never reach here, so no target ever sees them
        case (win_frame(in_idx))
          PFD_FRAME0: begin
            // Memory bus port keeps the CPU's own width
            f_port_reg[0] <= '{1'b1, in_req.write, in_req.wide, in_req.addr,
                               in_req.wdata};
          end
          PFD_FRAME1: begin
            f_port_reg[1] <= '{1'b1, in_req.write, in_req.wide, in_req.addr,
                               in_req.wdata};
          end
          PFD_FRAME2: begin
            // Low half first at the even address
            f_port_reg[2] <= '{1'b1, in_req.write, 1'b0, in_req.addr,
                               {16'h0000, in_req.wdata[15:0]}};
          end
          default: begin
            f_port_reg[3] <= '{1'b1, in_req.write, in_req.wide, in_req.addr,
                               in_req.wdata};
          end
        endcase
      end else if (state_reg == PFD_S_HALF) begin
        // High half at the next word address
        f_port_reg[2] <= '{1'b1, cur_reg.write, 1'b0, cur_reg.addr + 22'h000001,
                           {16'h0000, cur_reg.wdata[31:16]}};
      end
    end
  end

  // Read data collection and error flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else if (take) begin
      err_reg <= (in_kind == PFD_K_ERR);
      if (in_kind == PFD_K_LOCAL && !in_req.write) begin
        rdata_reg <= {16'h0000, map_rdata};
      end else begin
        // Dropped writes and hidden reads answer zero without error
        rdata_reg <= '0;
      end
    end else if (state_reg == PFD_S_ISSUE && f_ack[frm_reg] && !cur_reg.write) begin
      if (frm_reg == PFD_FRAME2) begin
        if (split_reg) begin
          rdata_reg[15:0] <= f_rdata[2][15:0];
        end else if (cur_reg.wide) begin
          rdata_reg[31:16] <= f_rdata[2][15:0];
        end else begin
          rdata_reg <= {16'h0000, f_rdata[2][15:0]};
        end
      end else if (cur_reg.wide) begin
        rdata_reg <= f_rdata[frm_reg];
      end else begin
        rdata_reg <= {16'h0000, f_rdata[frm_reg][15:0]};
      end
    end
  end

  // Answer pulse to the master that asked, shown in the done state only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rsp_reg <= '0;
      dma_rsp_reg <= '0;
    end else begin
      cpu_rsp_reg.done <= 1'b0;
      dma_rsp_reg.done <= 1'b0;
      if (state_next == PFD_S_DONE && state_reg != PFD_S_DONE) begin
        // Gap of one cycle after done lets the master drop its valid
        if (src_dma_sel()) begin
          dma_rsp_reg.done <= 1'b1;
          dma_rsp_reg.err <= next_err();
          dma_rsp_reg.rdata <= next_rdata();
        end else begin
          cpu_rsp_reg.done <= 1'b1;
          cpu_rsp_reg.err <= next_err();
          cpu_rsp_reg.rdata <= next_rdata();
        end
      end
    end
  end

  // Source of the answer being formed this cycle
  function automatic logic src_dma_sel();
    src_dma_sel = (state_reg == PFD_S_IDLE) ? in_dma : src_dma_reg;
  endfunction : src_dma_sel

  // Error of the answer being formed: unmapped or out of DMA reach
  function automatic logic next_err();
    next_err = (state_reg == PFD_S_IDLE) ? (in_kind == PFD_K_ERR) : err_reg;
  endfunction : next_err

  // Data of the answer being formed, taking the final beat straight off the port
  function automatic logic [31:0] next_rdata();
    logic [31:0] d;
    d = rdata_reg;
    if (state_reg == PFD_S_IDLE) begin
      d = (in_kind == PFD_K_LOCAL && !in_req.write) ? {16'h0000, map_rdata} : 32'h00000000;
    end else if (state_reg == PFD_S_ISSUE && !cur_reg.write) begin
      if (frm_reg == PFD_FRAME2) begin
        d = cur_reg.wide ? {f_rdata[2][15:0], rdata_reg[15:0]}
                         : {16'h0000, f_rdata[2][15:0]};
      end else begin
        d = cur_reg.wide ? f_rdata[frm_reg] : {16'h0000, f_rdata[frm_reg][15:0]};
      end
    end else if (state_reg == PFD_S_ISSUE) begin
      d = 32'h00000000;
    end
    next_rdata = d;
  endfunction : next_rdata
endmodule : pfd_frame_decoder

// ==== design/pfd_map_reg.sv ====
// Peripheral map configuration register with its remap bit
`timescale 1ns/10ps
module pfd_map_reg
  import pfd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_stb,
  input wire logic [15:0] wdata,
  input wire logic unlocked,
  output logic remap_reg,
  output logic [15:0] rdata
);
  // Remap bit, only written while writes are unlocked
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remap_reg <= PFD_MAPCFG_RESET;
    end else if (wr_stb && unlocked) begin
      remap_reg <= wdata[PFD_MAPCFG_REMAP_POS];
    end
  end

  // Upper bits read as zero
  assign rdata = {15'h0000, remap_reg};
endmodule : pfd_map_reg

// ==== design/pfd_window_decode.sv ====
// Address to window lookup with remap-dependent windows
`timescale 1ns/10ps
module pfd_window_decode
  import pfd_pkg::*;
(
  input wire logic [21:0] addr,
  input wire logic remap,
  output logic hit,
  output logic [4:0] idx
);
  // One match line per window
  logic [PFD_NWIN-1:0] match;

  // Range compare per window, pulse-width windows follow the remap bit
  generate
    for (genvar i = 0; i < PFD_NWIN; i++) begin : g_win
      logic [22:0] win_end;
      logic allowed;
      assign win_end = {1'b0, PFD_WIN_BASE[i]} + {1'b0, PFD_WIN_SIZE[i]};
      assign allowed = !(PFD_MASK_REMAP_ONLY[i] && !remap) &&
                       !(PFD_MASK_NORMAL_ONLY[i] && remap);
      assign match[i] = allowed && (addr >= PFD_WIN_BASE[i]) &&
                        ({1'b0, addr} < win_end);
    end
  endgenerate

  // Lowest index wins, so the map register beats the system block around it
  always_comb begin
    hit = |match;
    idx = 5'h00;
    for (int i = PFD_NWIN - 1; i >= 0; i--) begin
      if (match[i]) begin
        idx = 5'(i);
      end
    end
  end
endmodule : pfd_window_decode

// ==== inc/pfd_pkg.sv ====
// Shared types, address windows and timing constants of the peripheral frame decoder
package pfd_pkg;
  // Word address and data widths of the CPU side
  localparam int PFD_AW = 22;
  localparam int PFD_DW = 32;
  localparam int PFD_NWIN = 25;
  localparam int PFD_IW = 5;

  // Request from a bus master, held until its answer is seen
  typedef struct packed {
    logic valid;
    logic write;
    logic wide;
    logic [21:0] addr;
    logic [31:0] wdata;
  } pfd_req_t;

  // Answer to a bus master, done is a one-cycle pulse
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } pfd_rsp_t;

  // Access issued towards one peripheral frame, sel is a one-cycle pulse
  typedef struct packed {
    logic sel;
    logic write;
    logic wide;
    logic [21:0] addr;
    logic [31:0] wdata;
  } pfd_fport_t;

  // Window start addresses, in 16-bit words
  localparam logic [21:0] PFD_WIN_BASE [PFD_NWIN] = '{
    22'h000880, 22'h000a80, 22'h000ae0, 22'h000b00, 22'h000b20, 22'h000c00,
    22'h000ce0, 22'h000d00, 22'h001000, 22'h006000, 22'h006800, 22'h006a00,
    22'h006b00, 22'h006f80, 22'h00702e, 22'h007010, 22'h007040, 22'h007050,
    22'h007070, 22'h007100, 22'h007750, 22'h007770, 22'h007900, 22'h005000,
    22'h005800};
  // Window sizes, in 16-bit words
  localparam logic [21:0] PFD_WIN_SIZE [PFD_NWIN] = '{
    22'h000180, 22'h000060, 22'h000010, 22'h000010, 22'h000020, 22'h000040,
    22'h000020, 22'h000100, 22'h000200, 22'h000400, 22'h000180, 22'h0000c0,
    22'h000080, 22'h000080, 22'h000001, 22'h000020, 22'h000010, 22'h000010,
    22'h000010, 22'h000020, 22'h000010, 22'h000010, 22'h000040, 22'h000080,
    22'h000180};

  // Window attribute masks, bit i belongs to window i
  localparam logic [24:0] PFD_MASK_PROT = 25'h0004197;
  localparam logic [24:0] PFD_MASK_RO = 25'h0000008;
  localparam logic [24:0] PFD_MASK_CPROT = 25'h0000002;
  localparam logic [24:0] PFD_MASK_DMA = 25'h1800008;
  localparam logic [24:0] PFD_MASK_REMAP_ONLY = 25'h1000000;
  localparam logic [24:0] PFD_MASK_NORMAL_ONLY = 25'h0000400;

  // First window index of each frame above frame 0
  localparam logic [4:0] PFD_F1_FIRST = 5'h09;
  localparam logic [4:0] PFD_F2_FIRST = 5'h0e;
  localparam logic [4:0] PFD_F3_FIRST = 5'h17;
  localparam logic [4:0] PFD_WIN_MAPCFG = 5'h0e;
  localparam logic [4:0] PFD_WIN_ADCRES = 5'h03;

  // Register layout and reset values
  localparam logic [21:0] PFD_MAPCFG_OFFSET = 22'h00702e;
  localparam int PFD_MAPCFG_REMAP_POS = 0;
  localparam logic PFD_MAPCFG_RESET = 1'h0;
  localparam logic PFD_UNLOCK_RESET = 1'h0;

  // Extra cycles each master waits on the converter result window
  localparam logic [1:0] PFD_ADC_CPU_WAIT = 2'h1;
  localparam logic [1:0] PFD_ADC_DMA_WAIT = 2'h0;

  // Frame numbers
  localparam logic [1:0] PFD_FRAME0 = 2'h0;
  localparam logic [1:0] PFD_FRAME1 = 2'h1;
  localparam logic [1:0] PFD_FRAME2 = 2'h2;
  localparam logic [1:0] PFD_FRAME3 = 2'h3;

  // What the decoder does with a request
  typedef enum {PFD_K_ERR, PFD_K_DROP, PFD_K_ZERO, PFD_K_LOCAL, PFD_K_FRAME} pfd_kind_t;

  // Sequencer states
  typedef enum {PFD_S_IDLE, PFD_S_ISSUE, PFD_S_HALF, PFD_S_HOLD, PFD_S_DONE} pfd_state_t;
endpackage : pfd_pkg

// ==== tb/pfd_frame_decoder_asserts.sv ====
// Concurrent checks on the ports of the peripheral frame decoder
`timescale 1ns/10ps
module pfd_frame_decoder_asserts
  import pfd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic write_unlock_instr,
  input wire logic write_lock_instr,
  input wire logic cprot_open,
  input wire pfd_req_t cpu_req,
  input wire pfd_req_t dma_req,
  input wire logic [3:0] f_ack,
  input wire logic [3:0][31:0] f_rdata,
  input wire pfd_rsp_t cpu_rsp,
  input wire pfd_rsp_t dma_rsp,
  input wire pfd_fport_t [3:0] f_port,
  input wire logic unlock_state,
  input wire logic pwm_remap_bit
);
  // Protected window lookup, from the window tables
  function automatic logic is_prot(input logic [21:0] a);
    is_prot = 1'b0;
    for (int i = 0; i < PFD_NWIN; i++) begin
      if (PFD_MASK_PROT[i] && a >= PFD_WIN_BASE[i] && a < PFD_WIN_BASE[i] + PFD_WIN_SIZE[i]) begin
        is_prot = 1'b1;
      end
    end
  endfunction : is_prot
  // Frame selects gathered in one vector
  wire logic [3:0] sels = {f_port[3].sel, f_port[2].sel, f_port[1].sel, f_port[0].sel};
  // CPU write while locked and not being unlocked this cycle; the checks add the fresh request and the protected window
  wire logic lk_wr = cpu_req.valid && cpu_req.write && !unlock_state && !write_unlock_instr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_lock_clears: assert property (write_lock_instr |=> !unlock_state)
    else $error("unlock state survived a lock");
  a_unlock_sets: assert property (write_unlock_instr && !write_lock_instr |=> unlock_state)
    else $error("unlock state not set");
  a_locked_drop: assert property ($rose(cpu_req.valid) && lk_wr && is_prot(cpu_req.addr)
    |-> (sels == 4'h0) [*4])
    else $error("locked protected write reached a frame");
  a_locked_done: assert property ($rose(cpu_req.valid) && lk_wr && is_prot(cpu_req.addr)
    |-> ##[1:3] (cpu_rsp.done && !cpu_rsp.err))
    else $error("blocked write not answered quietly");
  a_one_frame: assert property ($onehot0(sels))
    else $error("two frames selected at once");
  a_frame0_local: assert property (f_port[0].sel |-> f_port[0].addr < 22'h002000)
    else $error("frame 0 select outside frame 0");
  a_remap_frame3: assert property (f_port[3].sel && f_port[3].addr >= 22'h005800
    |-> pwm_remap_bit)
    else $error("pulse-width frame 3 access while not remapped");
  a_normal_frame1: assert property (f_port[1].sel && f_port[1].addr >= 22'h006800
    && f_port[1].addr < 22'h006980 |-> !pwm_remap_bit)
    else $error("pulse-width frame 1 access while remapped");
  a_frame2_narrow: assert property (f_port[2].sel |-> !f_port[2].wide)
    else $error("wide beat on the 16-bit frame");
  a_remap_guard: assert property ($changed(pwm_remap_bit) |-> $past(unlock_state))
    else $error("remap bit changed while locked");
endmodule : pfd_frame_decoder_asserts

bind pfd_frame_decoder pfd_frame_decoder_asserts pfd_frame_decoder_asserts_i (
  .clk(clk), .reset_n(reset_n), .write_unlock_instr(write_unlock_instr),
  .write_lock_instr(write_lock_instr), .cprot_open(cprot_open), .cpu_req(cpu_req),
  .dma_req(dma_req), .f_ack(f_ack), .f_rdata(f_rdata), .cpu_rsp(cpu_rsp),
  .dma_rsp(dma_rsp), .f_port(f_port), .unlock_state(unlock_state),
  .pwm_remap_bit(pwm_remap_bit));

// ==== tb/pfd_frame_slave.sv ====
// Behavioural model of the four frame slaves behind the decoder
`timescale 1ns/10ps
module pfd_frame_slave
  import pfd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire pfd_fport_t [3:0] f_port,
  output logic [3:0] f_ack,
  output logic [3:0][31:0] f_rdata
);
  logic [15:0] mem [4][128]; // Register image, low address bits only, so windows alias
  logic [3:0] pend; // Answer owed per frame
  logic [3:0] wide_r; // Width of the owed answer
  logic [1:0] cnt [4]; // Stall left per frame
  logic [6:0] a_r [4]; // Word address of the owed answer
  // Store at select, answer next cycle or after a stall
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f_ack <= 4'h0;
      pend <= 4'h0;
      f_rdata <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        f_ack[k] <= 1'b0;
        f_rdata[k] <= ~f_rdata[k]; // Churns outside an answer so stale data never matches
        if (f_port[k].sel) begin
          a_r[k] <= f_port[k].addr[6:0];
          wide_r[k] <= f_port[k].wide;
          cnt[k] <= slow ? 2'h3 : 2'h0;
          pend[k] <= 1'b1;
          if (f_port[k].write) begin
            mem[k][f_port[k].addr[6:0]] <= f_port[k].wdata[15:0];
            // Wide unit keeps its high half at the next word
            if (f_port[k].wide) begin
              mem[k][f_port[k].addr[6:0] + 7'h01] <= f_port[k].wdata[31:16];
            end
          end
        end else if (pend[k]) begin
          if (cnt[k] == 2'h0) begin
            f_ack[k] <= 1'b1;
            pend[k] <= 1'b0;
            f_rdata[k] <= {wide_r[k] ? mem[k][a_r[k] + 7'h01] : 16'h0000, mem[k][a_r[k]]};
          end else begin
            cnt[k] <= cnt[k] - 2'h1;
          end
        end
      end
    end
  end
endmodule : pfd_frame_slave

// ==== tb/tb_top.sv ====
// Self-checking bench for the peripheral frame decoder
`timescale 1ns/10ps
module tb_top
  import pfd_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic unl = 1'b0; // Unlock instruction pulse
  logic lck = 1'b0; // Lock instruction pulse
  logic cprot = 1'b1; // Code protection open
  logic slow = 1'b0; // Partner stalls its answers
  pfd_req_t creq = '0;
  pfd_req_t dreq = '0;
  logic [3:0] f_ack;
  logic [3:0][31:0] f_rdata;
  pfd_rsp_t crsp;
  pfd_rsp_t drsp;
  pfd_fport_t [3:0] f_port;
  logic unlock_state;
  logic pwm_remap_bit;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat; // Cycles to the answer of the last access
  int lat2;
  logic [31:0] rd; // Read data of the last access
  logic er; // Error flag of the last access
  logic [1:0] last_fr = 2'h0; // Frame of the last select
  // Windows, protection and frame of each, walked in order
  localparam logic [21:0] T_ADDR [12] = '{22'h000880, 22'h000a80, 22'h000ae0, 22'h000b20,
    22'h000c00, 22'h000ce0, 22'h000d00, 22'h001000, 22'h006000, 22'h007040, 22'h005000,
    22'h006800};
  localparam logic [11:0] T_PROT = 12'b0000_1100_1111;
  localparam logic [1:0] T_FR [12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h2, 2'h3, 2'h1};

  pfd_frame_decoder pfd_frame_decoder_i (.clk(clk), .reset_n(reset_n),
    .write_unlock_instr(unl), .write_lock_instr(lck), .cprot_open(cprot), .cpu_req(creq),
    .dma_req(dreq), .f_ack(f_ack), .f_rdata(f_rdata), .cpu_rsp(crsp), .dma_rsp(drsp),
    .f_port(f_port), .unlock_state(unlock_state), .pwm_remap_bit(pwm_remap_bit));
  pfd_frame_slave pfd_frame_slave_i (.clk(clk), .reset_n(reset_n), .slow(slow),
    .f_port(f_port), .f_ack(f_ack), .f_rdata(f_rdata));

  // Clock at 4 ns
  initial begin
    forever #2 clk = ~clk;
  end
  // Hang guard and frame tracker
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 4; k++) begin
      if (f_port[k].sel === 1'b1) begin
        last_fr <= 2'(k);
      end
    end
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // One master access: hold until done, take the answer, drop at the next edge
  task automatic acc(input logic d, input logic w, input logic wd, input logic [21:0] a,
                     input logic [31:0] v);
    pfd_req_t r;
    pfd_rsp_t s;
    r = '{valid: 1'b1, write: w, wide: wd, addr: a, wdata: v};
    s = '0;
    lat = 0;
    @(posedge clk);
    #1;
    if (d) dreq = r;
    else creq = r;
    while (s.done !== 1'b1 && lat < 50) begin
      @(posedge clk);
      #1;
      s = d ? drsp : crsp;
      lat++;
    end
    check("done", 32'(s.done), 32'h1);
    rd = s.rdata;
    er = s.err;
    @(posedge clk);
    #1;
    creq = '0;
    dreq = '0;
  endtask : acc

  // Instruction pulses, one cycle wide
  task automatic pulse(input logic u, input logic l);
    @(posedge clk);
    #1;
    unl = u;
    lck = l;
    @(posedge clk);
    #1;
    unl = 1'b0;
    lck = 1'b0;
  endtask : pulse

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check("unlock reset", 32'(unlock_state), 32'h0);
    check("remap reset", 32'(pwm_remap_bit), 32'h0);
    // Locked write is lost on protected windows only; stall on odd entries
    for (int i = 0; i < 12; i++) begin
      slow = i[0];
      pulse(1'b1, 1'b0);
      acc(1'b0, 1'b1, 1'b0, T_ADDR[i], 32'h0000a5a5);
      pulse(1'b0, 1'b1);
      check("locked", 32'(unlock_state), 32'h0);
      acc(1'b0, 1'b1, 1'b0, T_ADDR[i], 32'h00005a5a);
      check("blocked err", 32'(er), 32'h0);
      acc(1'b0, 1'b0, 1'b0, T_ADDR[i], 32'h0);
      check("read back", 32'(rd[15:0]), T_PROT[i] ? 32'ha5a5 : 32'h5a5a);
      check("frame", 32'(last_fr), 32'(T_FR[i]));
    end
    slow = 1'b0;
    // Remap into frame 3, then a locked attempt to undo it
    pulse(1'b1, 1'b0);
    acc(1'b0, 1'b1, 1'b0, PFD_MAPCFG_OFFSET, 32'h0000ffff);
    acc(1'b0, 1'b0, 1'b0, PFD_MAPCFG_OFFSET, 32'h0);
    check("map read", 32'(rd[15:0]), 32'h1);
    acc(1'b0, 1'b0, 1'b0, 22'h005800, 32'h0);
    check("remap frame", 32'(last_fr), 32'h3);
    acc(1'b1, 1'b0, 1'b0, 22'h005840, 32'h0);
    check("dma frame 3 err", 32'(er), 32'h0);
    acc(1'b0, 1'b0, 1'b0, 22'h006800, 32'h0);
    check("old home err", 32'(er), 32'h1);
    pulse(1'b0, 1'b1);
    acc(1'b0, 1'b1, 1'b0, PFD_MAPCFG_OFFSET, 32'h0);
    check("remap held", 32'(pwm_remap_bit), 32'h1);
    // Reset in mid-run brings the windows home
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check("remap cleared", 32'(pwm_remap_bit), 32'h0);
    acc(1'b0, 1'b0, 1'b0, 22'h005800, 32'h0);
    check("frame 3 pwm err", 32'(er), 32'h1);
    // Converter results: one extra CPU wait, writes refused
    acc(1'b0, 1'b0, 1'b0, 22'h000b00, 32'h0);
    lat2 = lat;
    acc(1'b1, 1'b0, 1'b0, 22'h000b00, 32'h0);
    check("adc wait", 32'(lat2), 32'(lat + 1));
    check("dma adc data", 32'(rd[15:0]), 32'ha5a5);
    acc(1'b0, 1'b1, 1'b0, 22'h000b00, 32'h00001234);
    check("adc write err", 32'(er), 32'h0);
    acc(1'b0, 1'b0, 1'b0, 22'h000b00, 32'h0);
    check("adc unchanged", 32'(rd[15:0]), 32'ha5a5);
    acc(1'b1, 1'b0, 1'b0, 22'h006000, 32'h0);
    check("dma frame 1 err", 32'(er), 32'h1);
    // Wide units on frames 2 and 0
    acc(1'b0, 1'b1, 1'b1, 22'h007040, 32'h12345678);
    acc(1'b0, 1'b0, 1'b1, 22'h007040, 32'h0);
    check("frame 2 wide", rd, 32'h12345678);
    acc(1'b0, 1'b1, 1'b1, 22'h000c00, 32'h9abcdef0);
    acc(1'b0, 1'b0, 1'b1, 22'h000c00, 32'h0);
    check("frame 0 wide", rd, 32'h9abcdef0);
    acc(1'b0, 1'b0, 1'b0, 22'h000c01, 32'h0);
    check("frame 0 narrow", 32'(rd[15:0]), 32'h9abc);
    // Flash window closed by code protection, unmapped hole, lock beats unlock
    cprot = 1'b0;
    acc(1'b0, 1'b0, 1'b0, 22'h000a80, 32'h0);
    check("flash gated", rd, 32'h0);
    acc(1'b0, 1'b0, 1'b0, 22'h003000, 32'h0);
    check("unmapped err", 32'(er), 32'h1);
    pulse(1'b1, 1'b1);
    check("lock wins", 32'(unlock_state), 32'h0);
    results();
  end
endmodule : tb_top
